// ==== ipa_pkg.sv ====
// ipa_pkg: shared constants for the in-position and i/o assignment block
package ipa_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_RANGE    = 8'h00;
  localparam logic [7:0] REG_UNIT     = 8'h04;
  localparam logic [7:0] REG_COND     = 8'h08;
  localparam logic [7:0] REG_AUTO     = 8'h0c;
  localparam logic [7:0] REG_IN_A     = 8'h10;
  localparam logic [7:0] REG_IN_B     = 8'h14;
  localparam logic [7:0] REG_IN_C     = 8'h18;
  localparam logic [7:0] REG_OUT_A    = 8'h1c;
  localparam logic [7:0] REG_OUT_B    = 8'h20;
  localparam logic [7:0] REG_OUT_C    = 8'h24;
  localparam logic [7:0] REG_FILT     = 8'h28;
  localparam logic [7:0] REG_PINPOL   = 8'h2c;
  localparam logic [7:0] REG_DOGPOL   = 8'h30;
  localparam logic [7:0] REG_STATE    = 8'h34;
  localparam logic [7:0] REG_IRQ_STAT = 8'h38;
  localparam logic [7:0] REG_IRQ_MASK = 8'h3c;
  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [31:0] RANGE_RST   = 32'h0000_0640;
  localparam logic [3:0]  UNIT_CMD    = 4'h0;
  localparam logic [3:0]  UNIT_ENC    = 4'h1;
  localparam logic [3:0]  COND_RANGE  = 4'h0;
  localparam logic [3:0]  COND_CMD    = 4'h1;
  localparam logic [3:0]  COND_START  = 4'h2;
  localparam logic [3:0]  AUTO_RST    = 4'h0;
  localparam int          AUTO_FWD_BIT = 0;
  localparam int          AUTO_REV_BIT = 1;
  localparam logic [7:0]  DEV_FWD     = 8'h0a;
  localparam logic [7:0]  DEV_REV     = 8'h0b;
  localparam logic [7:0]  DEV_DOG     = 8'h22;
  localparam logic [7:0]  OUT_BRAKE   = 8'h05;
  localparam logic [7:0]  OUT_INPOS   = 8'h04;
  localparam logic [7:0]  OUT_FAULT   = 8'h03;
  localparam logic [3:0]  FILT_RST    = 4'h7;
  localparam logic [3:0]  POL_RST     = 4'h0;
  // irq status bits
  localparam int IRQ_SETTLE_ON  = 0;
  localparam int IRQ_SETTLE_OFF = 1;
  localparam int IRQ_FWD_CHG    = 2;
  localparam int IRQ_REV_CHG    = 3;
  // ************************************************************
  // timing: filter code 7 is 3.500 ms, each code step is equal
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_DFLT_NS  = 3500000;
  localparam int FILT_DFLT_CODE = 7;
  localparam int FILT_STEP_NS  = FILT_DFLT_NS / FILT_DFLT_CODE;
  localparam int FILT_STEP_CYC = FILT_STEP_NS / CLK_PERIOD_NS;
endpackage

// ==== ipa_inpos_io.sv ====
// ipa_inpos_io: in-position detector and assignable digital i/o
// Functional notes
// R1 - settled flag on while droop is at or below the range, per condition
// R2 - settled flag drops whenever droop rises above range; may toggle
// R3 - range register resets to 1600 pulses
// R4 - unit 0 compares command pulse droop, unit 1 encoder pulse droop
// R5 - condition 0 range only, 1 adds command done, 2 adds start off
// R6 - software should pick condition 1 under high-tracking control
// R7 - auto-on bits force forward and reverse travel limits on
// R8 - auto-on applies only to the travel limits, no other device
// R9 - each input pin routed by device code, defaults 0ah 0bh 22h
// R10 - each output pin driven by device code, defaults 05h 04h 03h
// R11 - debounce select filters inputs, default code 7h is 3.500 ms
// R12 - pin sense 0 means high level on, 1 means low level on
// R13 - software should keep protection inputs at high-level-on sense
// R14 - home sensor sense 0 means dog detected while input off
// R15 - filtered level changes only after raw level stable for filter time
`timescale 1ns/10ps
module ipa_inpos_io import ipa_pkg::*; #(
  parameter int FILT_STEP = FILT_STEP_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic [31:0] droopCmd,
  input  wire logic [31:0] droopEnc,
  input  wire logic        cmdDone,
  input  wire logic        startSig,
  input  wire logic        brakeInterlock,
  input  wire logic        faultOutput,
  input  wire logic [2:0]  inPins,
  output logic      [2:0]  outPins,
  output logic             positionSettledFlag,
  output logic             fwdTravelLimit,
  output logic             revTravelLimit,
  output logic             homeSensorDetect,
  output logic             irq
);
  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [31:0] rangeQ, rangeD;
  logic [3:0]  unitQ, unitD, condQ, condD, autoQ, autoD;
  logic [7:0]  inRouteQ [3];
  logic [7:0]  inRouteD [3];
  logic [7:0]  outRouteQ [3];
  logic [7:0]  outRouteD [3];
  logic [3:0]  filtSelQ, filtSelD, pinPolQ, pinPolD, dogPolQ, dogPolD;
  logic [3:0]  irqStatQ, irqStatD, irqMaskQ, irqMaskD, irqEvt;
  logic [31:0] rdDataD;
  logic        irqD;
  logic [2:0]  syncAQ, syncBQ, syncCQ, filtQ, filtD;
  logic [19:0] fcntQ [3];
  logic [19:0] fcntD [3];
  logic [19:0] filtLimit;
  logic [2:0]  pinOn, outD;
  logic        settledD, fwdD, revD, dogD, rangeHit, condOk;
  logic        fwdRaw, revRaw, dogRaw;

  // register writes; irq status set wins over a same-cycle clear
  always_comb begin
    rangeD = rangeQ;
    unitD = unitQ;
    condD = condQ;
    autoD = autoQ;
    inRouteD = inRouteQ;
    outRouteD = outRouteQ;
    filtSelD = filtSelQ;
    pinPolD = pinPolQ;
    dogPolD = dogPolQ;
    irqMaskD = irqMaskQ;
    irqStatD = irqStatQ;
    if (regWr) begin
      if (regAddr == REG_RANGE) begin
        rangeD = regWrData; // [R3]
      end else if (regAddr == REG_UNIT) begin
        unitD = regWrData[3:0];
      end else if (regAddr == REG_COND) begin
        condD = regWrData[3:0];
      end else if (regAddr == REG_AUTO) begin
        autoD = regWrData[3:0];
      end else if (regAddr == REG_IN_A) begin
        inRouteD[0] = regWrData[7:0];
      end else if (regAddr == REG_IN_B) begin
        inRouteD[1] = regWrData[7:0];
      end else if (regAddr == REG_IN_C) begin
        inRouteD[2] = regWrData[7:0];
      end else if (regAddr == REG_OUT_A) begin
        outRouteD[0] = regWrData[7:0];
      end else if (regAddr == REG_OUT_B) begin
        outRouteD[1] = regWrData[7:0];
      end else if (regAddr == REG_OUT_C) begin
        outRouteD[2] = regWrData[7:0];
      end else if (regAddr == REG_FILT) begin
        filtSelD = regWrData[3:0];
      end else if (regAddr == REG_PINPOL) begin
        pinPolD = regWrData[3:0];
      end else if (regAddr == REG_DOGPOL) begin
        dogPolD = regWrData[3:0];
      end else if (regAddr == REG_IRQ_STAT) begin
        irqStatD = irqStatQ & ~regWrData[3:0];
      end else if (regAddr == REG_IRQ_MASK) begin
        irqMaskD = regWrData[3:0];
      end
    end
    irqStatD = irqStatD | irqEvt;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rangeQ <= RANGE_RST;
      unitQ <= UNIT_CMD;
      condQ <= COND_RANGE;
      autoQ <= AUTO_RST;
      inRouteQ <= '{DEV_FWD, DEV_REV, DEV_DOG}; // [R9]
      outRouteQ <= '{OUT_BRAKE, OUT_INPOS, OUT_FAULT}; // [R10]
      filtSelQ <= FILT_RST; // [R11]
      pinPolQ <= POL_RST;
      dogPolQ <= POL_RST;
      irqStatQ <= 4'h0;
      irqMaskQ <= 4'h0;
    end else begin
      rangeQ <= rangeD;
      unitQ <= unitD;
      condQ <= condD;
      autoQ <= autoD;
      inRouteQ <= inRouteD;
      outRouteQ <= outRouteD;
      filtSelQ <= filtSelD;
      pinPolQ <= pinPolD;
      dogPolQ <= dogPolD;
      irqStatQ <= irqStatD;
      irqMaskQ <= irqMaskD;
    end
  end

  // ************************************************************
  // read port: data stands only in the cycle after the strobe
  // ************************************************************
  always_comb begin
    rdDataD = 32'h0;
    if (regRd) begin
      if (regAddr == REG_RANGE) begin
        rdDataD = rangeQ;
      end else if (regAddr == REG_UNIT) begin
        rdDataD = {28'h0, unitQ};
      end else if (regAddr == REG_COND) begin
        rdDataD = {28'h0, condQ};
      end else if (regAddr == REG_AUTO) begin
        rdDataD = {28'h0, autoQ};
      end else if (regAddr == REG_IN_A) begin
        rdDataD = {24'h0, inRouteQ[0]};
      end else if (regAddr == REG_IN_B) begin
        rdDataD = {24'h0, inRouteQ[1]};
      end else if (regAddr == REG_IN_C) begin
        rdDataD = {24'h0, inRouteQ[2]};
      end else if (regAddr == REG_OUT_A) begin
        rdDataD = {24'h0, outRouteQ[0]};
      end else if (regAddr == REG_OUT_B) begin
        rdDataD = {24'h0, outRouteQ[1]};
      end else if (regAddr == REG_OUT_C) begin
        rdDataD = {24'h0, outRouteQ[2]};
      end else if (regAddr == REG_FILT) begin
        rdDataD = {28'h0, filtSelQ};
      end else if (regAddr == REG_PINPOL) begin
        rdDataD = {28'h0, pinPolQ};
      end else if (regAddr == REG_DOGPOL) begin
        rdDataD = {28'h0, dogPolQ};
      end else if (regAddr == REG_STATE) begin
        rdDataD = {24'h0, positionSettledFlag, homeSensorDetect,
                   revTravelLimit, fwdTravelLimit, 1'b0, filtQ};
      end else if (regAddr == REG_IRQ_STAT) begin
        rdDataD = {28'h0, irqStatQ};
      end else if (regAddr == REG_IRQ_MASK) begin
        rdDataD = {28'h0, irqMaskQ};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= 32'h0;
    end else begin
      regRdData <= rdDataD;
    end
  end

  // ************************************************************
  // pin synchroniser and debounce filter
  // ************************************************************
  // three stages; only the second and third are looked at
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncAQ <= 3'h0;
      syncBQ <= 3'h0;
      syncCQ <= 3'h0;
    end else begin
      syncAQ <= inPins;
      syncBQ <= syncAQ;
      syncCQ <= syncBQ;
    end
  end

  // code 0 passes with no delay; code n needs n steps of stability
  assign filtLimit = 20'(filtSelQ) * 20'(FILT_STEP);

  for (genvar i = 0; i < 3; i++) begin : gFilt
    always_comb begin
      filtD[i] = filtQ[i];
      fcntD[i] = 20'h0;
      if ((syncBQ[i] == syncCQ[i]) && (syncCQ[i] != filtQ[i])) begin
        if ((filtSelQ == 4'h0) || (fcntQ[i] >= filtLimit - 20'h1)) begin
          filtD[i] = syncCQ[i]; // [R15] [R11]
        end else begin
          fcntD[i] = fcntQ[i] + 20'h1;
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        filtQ[i] <= 1'b0;
        fcntQ[i] <= 20'h0;
      end else begin
        filtQ[i] <= filtD[i];
        fcntQ[i] <= fcntD[i];
      end
    end
  end

  // ************************************************************
  // input device routing, sense and auto-on
  // ************************************************************
  // a pin routed to an unknown code simply feeds nothing
  always_comb begin
    pinOn = filtQ ^ {3{pinPolQ[0]}}; // [R12]
    fwdRaw = 1'b0;
    revRaw = 1'b0;
    dogRaw = 1'b0;
    for (int k = 0; k < 3; k++) begin
      fwdRaw = fwdRaw | (pinOn[k] & (inRouteQ[k] == DEV_FWD)); // [R9]
      revRaw = revRaw | (pinOn[k] & (inRouteQ[k] == DEV_REV));
      dogRaw = dogRaw | (pinOn[k] & (inRouteQ[k] == DEV_DOG));
    end
    // forcing reaches the two travel limits only
    fwdD = fwdRaw | autoQ[AUTO_FWD_BIT]; // [R7] [R8]
    revD = revRaw | autoQ[AUTO_REV_BIT]; // [R7]
    dogD = dogPolQ[0] ? dogRaw : ~dogRaw; // [R14] [R8]
  end

  // ************************************************************
  // in-position detector
  // ************************************************************
  // no hysteresis: overshoot around the range edge toggles the flag
  always_comb begin
    if (unitQ[0]) begin
      rangeHit = droopEnc <= rangeQ; // [R4]
    end else begin
      rangeHit = droopCmd <= rangeQ; // [R4]
    end
    // codes above 2 behave as the strictest condition
    if (condQ == COND_RANGE) begin
      condOk = 1'b1;
    end else if (condQ == COND_CMD) begin
      condOk = cmdDone; // [R5] [R6]
    end else begin
      condOk = cmdDone & ~startSig; // [R5]
    end
    settledD = rangeHit & condOk; // [R1] [R2]
  end

  // output pins flop the routed device levels (brake and fault straight from their inputs), one cycle behind
  for (genvar j = 0; j < 3; j++) begin : gOut
    always_comb begin
      if (outRouteQ[j] == OUT_BRAKE) begin
        outD[j] = brakeInterlock; // [R10]
      end else if (outRouteQ[j] == OUT_INPOS) begin
        outD[j] = positionSettledFlag; // [R10]
      end else if (outRouteQ[j] == OUT_FAULT) begin
        outD[j] = faultOutput;
      end else begin
        outD[j] = 1'b0;
      end
    end
  end

  // events: settle edges and travel limit changes
  always_comb begin
    irqEvt = 4'h0;
    irqEvt[IRQ_SETTLE_ON] = settledD & ~positionSettledFlag;
    irqEvt[IRQ_SETTLE_OFF] = ~settledD & positionSettledFlag;
    irqEvt[IRQ_FWD_CHG] = fwdD ^ fwdTravelLimit;
    irqEvt[IRQ_REV_CHG] = revD ^ revTravelLimit;
    irqD = |(irqStatQ & irqMaskQ);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      positionSettledFlag <= 1'b0;
      fwdTravelLimit <= 1'b0;
      revTravelLimit <= 1'b0;
      homeSensorDetect <= 1'b0;
      outPins <= 3'h0;
      irq <= 1'b0;
    end else begin
      positionSettledFlag <= settledD;
      fwdTravelLimit <= fwdD;
      revTravelLimit <= revD;
      homeSensorDetect <= dogD;
      outPins <= outD;
      irq <= irqD;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_settled_in_range: assert property ( // [R1]
    (droopCmd <= rangeQ && !unitQ[0] && condQ == COND_RANGE)
      |=> positionSettledFlag)
    else $error("settled flag missing inside range");
  a_settled_leaves: assert property ( // [R2]
    (unitQ == UNIT_CMD && droopCmd > rangeQ) |=> !positionSettledFlag)
    else $error("settled flag held above range");
  a_range_reset: assert property ( // [R3]
    $past(rst) |-> (rangeQ == RANGE_RST))
    else $error("range reset value wrong");
  a_unit_encoder: assert property ( // [R4]
    (unitQ == UNIT_ENC && condQ == COND_RANGE)
      |=> (positionSettledFlag == ($past(droopEnc) <= $past(rangeQ))))
    else $error("encoder unit not used");
  a_cond_command: assert property ( // [R5]
    (condQ == COND_CMD && !cmdDone) |=> !positionSettledFlag)
    else $error("settled without command done");
  a_cond_start: assert property ( // [R5]
    (condQ == COND_START && startSig) |=> !positionSettledFlag)
    else $error("settled while start is on");
  a_auto_forced: assert property ( // [R7]
    autoQ[AUTO_FWD_BIT] |=> fwdTravelLimit)
    else $error("auto-on did not force forward limit");
  a_auto_subset: assert property ( // [R8]
    (dogPolQ[0] && inRouteQ[0] != DEV_DOG && inRouteQ[1] != DEV_DOG
      && inRouteQ[2] != DEV_DOG) |=> !homeSensorDetect)
    else $error("home sensor forced without a pin");
  a_dog_sense: assert property ( // [R14]
    (dogPolQ == POL_RST && inRouteQ[2] == DEV_DOG && inRouteQ[0] != DEV_DOG
      && inRouteQ[1] != DEV_DOG) |=> (homeSensorDetect == !$past(pinOn[2])))
    else $error("home sensor sense wrong");
  a_pin_sense: assert property ( // [R12]
    (inRouteQ[0] == DEV_FWD && inRouteQ[1] != DEV_FWD && inRouteQ[2] != DEV_FWD
      && !autoQ[AUTO_FWD_BIT])
      |=> (fwdTravelLimit == ($past(filtQ[0]) ^ $past(pinPolQ[0]))))
    else $error("pin sense or routing wrong");
  a_out_route: assert property ( // [R10]
    (outRouteQ[1] == OUT_INPOS) |=> (outPins[1] == $past(positionSettledFlag)))
    else $error("output pin not following settled flag");
  a_filter_wait: assert property ( // [R15]
    ($changed(filtQ[0]) && $past(filtSelQ) != 4'h0)
      |-> ($past(fcntQ[0]) == $past(filtLimit) - 20'h1))
    else $error("filter passed level early");
  a_irq_level: assert property (
    (|(irqStatQ & irqMaskQ)) |=> irq)
    else $error("interrupt not raised");

  c_settle_rise: cover property (!positionSettledFlag ##1 positionSettledFlag);
  c_auto_fwd: cover property (autoQ[AUTO_FWD_BIT] ##1 fwdTravelLimit);
  c_filter_pass: cover property (filtSelQ != 4'h0 ##0 $changed(filtQ[0]));
  c_irq_high: cover property (irq);
endmodule

// ==== ipa_field_model.sv ====
// ipa_field_model: field wiring that feeds the three raw input pins
`timescale 1ns/10ps
module ipa_field_model import ipa_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic [2:0] pinReq,
  input  wire logic       bounceEn,
  output logic      [2:0] inPins
);
  logic [2:0] lastReq = 3'h0;
  logic [1:0] bounceCnt = 2'h0;
  // contacts bounce for a few cycles after a change, only when asked to
  always @(posedge core_clk) begin
    if (bounceEn && pinReq != lastReq) begin
      bounceCnt <= 2'h3;
    end else if (bounceCnt != 2'h0) begin
      bounceCnt <= bounceCnt - 2'h1;
    end
    lastReq <= pinReq;
  end
  // limit switches wired so that 24 V (a one) means on
  assign inPins = bounceCnt[0] ? ~pinReq : pinReq;
endmodule

// ==== inpos_and_io_assign_tb_top.sv ====
// inpos_and_io_assign_tb_top: self-checking bench for the in-position and i/o block
`timescale 1ns/10ps
module inpos_and_io_assign_tb_top import ipa_pkg::*; ;
  localparam int FSTEP = 4;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic [31:0] droopCmd = 32'h0;
  logic [31:0] droopEnc = 32'h0;
  logic        cmdDone = 1'b0;
  logic        startSig = 1'b0;
  logic        brakeInterlock = 1'b0;
  logic        faultOutput = 1'b0;
  logic [2:0]  pinReq = 3'h0;
  logic        bounceEn = 1'b0;
  logic [2:0]  inPins;
  logic [2:0]  outPins;
  logic        settled;
  logic        fwd;
  logic        rev;
  logic        home;
  logic        irq;
  int          n_mismatch = 0;
  int          checks = 0;
  logic [15:0] rnd = 16'he72d;
  logic [7:0]  rAddr [13] = '{REG_RANGE, REG_UNIT, REG_COND, REG_AUTO, REG_IN_A, REG_IN_B,
    REG_IN_C, REG_OUT_A, REG_OUT_B, REG_OUT_C, REG_FILT, REG_PINPOL, REG_DOGPOL};
  logic [31:0] rRst [13] = '{RANGE_RST, 32'h0, 32'h0, 32'h0, 32'h0a, 32'h0b, 32'h22,
    32'h05, 32'h04, 32'h03, 32'h7, 32'h0, 32'h0};

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  ipa_field_model field_u (.core_clk(core_clk), .pinReq(pinReq), .bounceEn(bounceEn),
    .inPins(inPins));

  ipa_inpos_io #(.FILT_STEP(FSTEP)) dut_u (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .droopCmd(droopCmd), .droopEnc(droopEnc), .cmdDone(cmdDone),
    .startSig(startSig), .brakeInterlock(brakeInterlock), .faultOutput(faultOutput),
    .inPins(inPins), .outPins(outPins), .positionSettledFlag(settled),
    .fwdTravelLimit(fwd), .revTravelLimit(rev), .homeSensorDetect(home), .irq(irq));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // settled flag expected from range test plus the chosen turn-on condition
  function automatic logic expSet(input logic inR, input int c, input logic dn,
      input logic st);
    return inR && (c == 0 || dn) && (c < 2 || !st);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // cycles until a filtered output reaches one, bounded
  task automatic waitOn(input int sel, output int n);
    n = 0;
    while (((sel == 0) ? fwd : rev) !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog: whole run needs well under 20000 cycles
  // ************************************************************
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] rng;
    logic [31:0] dp;
    int          n;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk(32'(home), 32'h1);
    for (int i = 0; i < 13; i++) begin
      rd(rAddr[i], d);
      chk(d, rRst[i]);
    end
    rd(8'hfc, d);
    chk(d, 32'h0);
    $display("test reset values done");
    // random droop around a random range, every unit and condition
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      rng = {16'h0, rnd};
      wr(REG_RANGE, rng);
      wr(REG_UNIT, 32'(rnd[0]));
      wr(REG_COND, 32'(i % 3));
      rd(REG_RANGE, d);
      chk(d, rng);
      dp = rng + 32'(rnd[3:1]) - 32'h4;
      @(posedge core_clk);
      droopCmd <= rnd[0] ? ~dp : dp;
      droopEnc <= rnd[0] ? dp : ~dp;
      cmdDone <= rnd[4];
      startSig <= rnd[5];
      tick(1);
      chk(32'(settled), 32'(expSet(dp <= rng, i % 3, rnd[4], rnd[5])));
      tick(1);
      chk(32'(outPins[1]), 32'(expSet(dp <= rng, i % 3, rnd[4], rnd[5])));
    end
    $display("test settle detector done");
    // interrupt: masked event stays quiet, unmasked one raises irq until cleared
    wr(REG_UNIT, 32'h0);
    wr(REG_COND, 32'h1);
    wr(REG_COND, 32'h0);
    wr(REG_RANGE, 32'h64);
    @(posedge core_clk);
    droopCmd <= 32'h1f4;
    tick(3);
    wr(REG_IRQ_STAT, 32'hf);
    wr(REG_IRQ_MASK, 32'h1);
    tick(2);
    chk(32'(irq), 32'h0);
    @(posedge core_clk);
    droopCmd <= 32'h32;
    tick(3);
    chk(32'(irq), 32'h1);
    rd(REG_IRQ_STAT, d);
    chk(d, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    tick(2);
    chk(32'(irq), 32'h0);
    @(posedge core_clk);
    droopCmd <= 32'h1f4;
    tick(3);
    chk(32'(irq), 32'h0);
    rd(REG_IRQ_STAT, d);
    chk(d, 32'h2);
    $display("test interrupt done");
    // output routing, including a code that drives nothing
    wr(REG_OUT_A, 32'h04);
    wr(REG_OUT_B, 32'h05);
    wr(REG_OUT_C, 32'h00);
    @(posedge core_clk);
    brakeInterlock <= 1'b1;
    faultOutput <= 1'b1;
    tick(3);
    chk(32'(outPins), 32'h2);
    wr(REG_OUT_C, 32'h03);
    tick(2);
    chk(32'(outPins), 32'h6);
    $display("test output routing done");
    // debounce: short glitch ignored, bouncing contact settles after filter time
    wr(REG_FILT, 32'h2);
    @(posedge core_clk);
    pinReq <= 3'h1;
    repeat (3) @(posedge core_clk);
    pinReq <= 3'h0;
    tick(20);
    chk(32'(fwd), 32'h0);
    @(posedge core_clk);
    bounceEn <= 1'b1;
    pinReq <= 3'h1;
    waitOn(0, n);
    chk(32'(n >= 2 * FSTEP && n <= 2 * FSTEP + 12), 32'h1);
    @(posedge core_clk);
    bounceEn <= 1'b0;
    wr(REG_FILT, 32'h0);
    @(posedge core_clk);
    pinReq <= 3'h3;
    waitOn(1, n);
    chk(32'(n >= 2 && n <= 8), 32'h1);
    $display("test debounce done");
    // pin sense inverted: high pins off, low dog pin on, so dog not detected
    wr(REG_PINPOL, 32'h1);
    tick(12);
    chk(32'({fwd, rev, home}), 32'h0);
    wr(REG_PINPOL, 32'h0);
    tick(12);
    chk(32'({fwd, rev, home}), 32'h7);
    // pin a rerouted to the dog device, contacts opened
    wr(REG_IN_A, 32'(DEV_DOG));
    tick(12);
    chk(32'({fwd, rev, home}), 32'h2);
    @(posedge core_clk);
    pinReq <= 3'h0;
    tick(12);
    wr(REG_IN_A, 32'(DEV_FWD));
    tick(2);
    chk(32'({fwd, rev, home}), 32'h1);
    // automatic on for both limits, upper bits have no effect
    wr(REG_AUTO, 32'h3);
    tick(2);
    chk(32'({fwd, rev, home}), 32'h7);
    wr(REG_AUTO, 32'hc);
    tick(2);
    chk(32'({fwd, rev, home}), 32'h1);
    // dog sense 1: detected while the pin is on; unrouted dog never forced
    wr(REG_DOGPOL, 32'h1);
    tick(2);
    chk(32'(home), 32'h0);
    @(posedge core_clk);
    pinReq <= 3'h4;
    tick(12);
    chk(32'({fwd, rev, home}), 32'h1);
    wr(REG_IN_C, 32'h00);
    tick(2);
    chk(32'({fwd, rev, home}), 32'h0);
    $display("test routing and forcing done");
    summarize();
  end
endmodule
